// ==== pbc_consts.vh ====
// constants for the pad buffer configuration register bank
`ifndef PBC_CONSTS_VH
`define PBC_CONSTS_VH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define PBC_OFS_P0L        12'h220
`define PBC_OFS_P0H        12'h224
`define PBC_OFS_P1L        12'h228
`define PBC_OFS_P1H        12'h22C
`define PBC_OFS_P2L        12'h230
`define PBC_OFS_P2H        12'h234
`define PBC_OFS_UNLOCK     12'h300
`define PBC_OFS_STATUS     12'h304
`define PBC_NUM_REGS       6
`define PBC_ADDR_W         12

// ----------------------------------------
// reset values and field layout
// ----------------------------------------
`define PBC_RST_VAL        16'h9999
`define PBC_PULL_NONE      2'h0
`define PBC_PULL_DOWN      2'h1
`define PBC_PULL_UP        2'h2
`define PBC_DRV_6MA        2'h1
`define PBC_DRV_12MA       2'h3
`define PBC_FIXED_DRV      2'h1
`define PBC_GRP_PU_BIT     3
`define PBC_GRP_PD_BIT     2
// bit set means that pin group has drive control (per register, 4 groups)
`define PBC_DRV_MASK_P0L   4'hF
`define PBC_DRV_MASK_P0H   4'hF
`define PBC_DRV_MASK_P1L   4'h0
`define PBC_DRV_MASK_P1H   4'h0
`define PBC_DRV_MASK_P2L   4'hF
`define PBC_DRV_MASK_P2H   4'hE

// ----------------------------------------
// unlock sequence keys
// ----------------------------------------
`define PBC_KEY_A          16'h00A5
`define PBC_KEY_B          16'h005A

`endif

// ==== pbc_regs.v ====
// pad buffer configuration register bank with write protection
//
// Behaviour
// - registers take 32-bit or 16-bit accesses
// - writes accepted only after unlock sequence
// - reads always allowed, no unlock needed
// - pull field 00 none, 01 down, 10 up
// - drive field 01 is 6mA, 11 is 12mA
// - four 4-bit pin groups, pull-up on top
// - bits 31..16 read as zero
// - pins without drive control read 01
// - port0 at 0x220/0x224, ports follow stepwise
// - settings apply in port and control mode
// - new pull setting drives pad immediately
//
// Our own choice: strobed register access.
`timescale 1ns/1ps
`include "pbc_consts.vh"

module pbc_regs (
  input  wire                   sys_clk,
  input  wire                   sys_rst,
  input  wire [`PBC_ADDR_W-1:0] bus_addr,
  input  wire [31:0]            bus_wdata,
  input  wire                   bus_wr,
  input  wire                   bus_rd,
  input  wire                   bus_half,
  output reg  [31:0]            bus_rdata,
  output reg  [23:0]            pad_pullup_en,
  output reg  [23:0]            pad_pulldown_en,
  output reg  [47:0]            pad_drive_sel
);

  // ----------------------------------------
  // address decode
  // ----------------------------------------
  wire [`PBC_NUM_REGS*16-1:0] cfg_flat;
  wire [5:0]                  reg_hit;
  wire                        unlock_hit;
  wire                        status_hit;
  wire                        unlocked;
  wire                        cfg_wr_any;
  wire [`PBC_NUM_REGS*4-1:0]  drv_mask;
  wire                        hi_half;

  assign drv_mask = {`PBC_DRV_MASK_P2H, `PBC_DRV_MASK_P2L, `PBC_DRV_MASK_P1H,
                     `PBC_DRV_MASK_P1L, `PBC_DRV_MASK_P0H, `PBC_DRV_MASK_P0L};

  // ----------------------------------------
  // request qualifiers
  // ----------------------------------------
  wire [`PBC_ADDR_W-1:0]      word_addr;
  wire                        wr_req;
  wire                        rd_req;
  wire                        cfg_hit;
  wire [15:0]                 wr_word;
  wire                        wr_lane_ok;
  wire [`PBC_NUM_REGS-1:0]    cfg_wr_en;
  wire [`PBC_NUM_REGS*16-1:0] nxt_flat;

  // lane bits dropped here; bit 1 only steers 16-bit accesses
  assign word_addr = {bus_addr[`PBC_ADDR_W-1:2], 2'b00};
  // the slave never stalls, so a strobe is a whole request
  assign wr_req    = bus_wr;
  assign rd_req    = bus_rd;

  assign reg_hit[0] = (word_addr == `PBC_OFS_P0L);
  assign reg_hit[1] = (word_addr == `PBC_OFS_P0H);
  assign reg_hit[2] = (word_addr == `PBC_OFS_P1L);
  assign reg_hit[3] = (word_addr == `PBC_OFS_P1H);
  assign reg_hit[4] = (word_addr == `PBC_OFS_P2L);
  assign reg_hit[5] = (word_addr == `PBC_OFS_P2H);
  assign unlock_hit = (word_addr == `PBC_OFS_UNLOCK);
  assign status_hit = (word_addr == `PBC_OFS_STATUS);
  // any of the six configuration words
  assign cfg_hit    = |reg_hit;

  // ----------------------------------------
  // write lane steering
  // ----------------------------------------
  // a 16-bit access to the upper half hits only the always-zero bits
  assign hi_half    = bus_half & bus_addr[1];
  // only the low half-word carries storage
  assign wr_word    = bus_wdata[15:0];
  assign wr_lane_ok = ~hi_half;

  // consumed by the first accepted config write
  assign cfg_wr_any = wr_req & cfg_hit & unlocked & wr_lane_ok;

  // ----------------------------------------
  // protection sequencer
  // ----------------------------------------
  pbc_unlock u_unlock (
    .sys_clk     (sys_clk),
    .sys_rst     (sys_rst),
    .key_wr      (wr_req & unlock_hit),
    .key_data    (wr_word),
    .cfg_wr_done (cfg_wr_any),
    .unlocked_r  (unlocked)
  );

  // ----------------------------------------
  // per register storage
  // ----------------------------------------
  genvar g;
  genvar p;
  generate
    for (g = 0; g < `PBC_NUM_REGS; g = g + 1) begin : g_reg
      reg  [15:0] cfg_r;
      reg  [15:0] cfg_nxt;
      wire [15:0] wmask;
      // drive bits of pins without drive control are forced to 01
      for (p = 0; p < 4; p = p + 1) begin : g_pin
        // pull bits always writable; drive bits only where the group has drive control
        assign wmask[p*4+3 -: 2] = 2'h3;
        assign wmask[p*4+1 -: 2] = drv_mask[g*4+p] ? 2'h3 : 2'h0;
      end

      // one write enable per word, only while open
      assign cfg_wr_en[g] = wr_req & reg_hit[g] & unlocked & wr_lane_ok;

      // locked writes leave value as is
      always @* begin
        cfg_nxt = cfg_r;
        if (cfg_wr_en[g]) begin
          cfg_nxt = (wr_word & wmask) | (cfg_r & ~wmask);
        end
      end

      always @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
          cfg_r <= `PBC_RST_VAL;
        end else begin
          cfg_r <= cfg_nxt;
        end
      end
      assign cfg_flat[g*16+15 -: 16] = cfg_r;
      assign nxt_flat[g*16+15 -: 16] = cfg_nxt;
    end
  endgenerate

  // ----------------------------------------
  // pin field view
  // ----------------------------------------
  wire [23:0] pu_sel_nxt;
  wire [23:0] pd_sel_nxt;
  wire [47:0] drv_code_nxt;
  genvar      n;

  // split next register values into per pin fields, pin n in group n
  generate
    for (n = 0; n < `PBC_NUM_REGS*4; n = n + 1) begin : g_field
      // group bits: pull-up, pull-down, drive pair
      assign pu_sel_nxt[n]            = nxt_flat[n*4+`PBC_GRP_PU_BIT];
      assign pd_sel_nxt[n]            = nxt_flat[n*4+`PBC_GRP_PD_BIT];
      assign drv_code_nxt[n*2+1 -: 2] = nxt_flat[n*4+1 -: 2];
    end
  endgenerate

  // ----------------------------------------
  // pad control outputs
  // ----------------------------------------
  // one process drives all pad ports, so every bit has a single driver
  // pads take a new setting on the write edge itself
  // no mode input, so port and control mode see the same
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pad_pullup_en   <= {24{1'b1}};
      pad_pulldown_en <= {24{1'b0}};
      pad_drive_sel   <= {24{`PBC_FIXED_DRV}};
    end else begin
      pad_pullup_en   <= pu_sel_nxt;
      // 11 is prohibited; pull-up wins to avoid a crowbar
      pad_pulldown_en <= pd_sel_nxt & ~pu_sel_nxt;
      // drive code reaches the pad as stored
      pad_drive_sel   <= drv_code_nxt;
    end
  end

  // ----------------------------------------
  // read path
  // ----------------------------------------
  reg [31:0] rdata_nxt;
  integer    i;

  always @* begin
    rdata_nxt = 32'h0000_0000;
    for (i = 0; i < `PBC_NUM_REGS; i = i + 1) begin
      if (reg_hit[i]) begin
        rdata_nxt = {16'h0000, cfg_flat[i*16 +: 16]};
      end
    end
    if (status_hit) begin
      rdata_nxt = {31'h0000_0000, unlocked};
    end
    // 16-bit read of upper half lands in low lanes
    if (hi_half) begin
      rdata_nxt = {16'h0000, rdata_nxt[31:16]};
    end
  end

  // read data valid one cycle after the strobe only
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      bus_rdata <= 32'h0000_0000;
    end else if (rd_req) begin
      bus_rdata <= rdata_nxt;
    end else begin
      bus_rdata <= 32'h0000_0000;
    end
  end

endmodule

// ==== pbc_regs_monitor.sv ====
// assertion checker for the pad buffer configuration bank
`timescale 1ns/1ps
module pbc_regs_monitor (
  input logic        sys_clk,
  input logic        sys_rst,
  input logic [11:0] bus_addr,
  input logic        bus_wr,
  input logic        bus_rd,
  input logic        bus_half,
  input logic [31:0] bus_rdata,
  input logic [23:0] pad_pullup_en,
  input logic [23:0] pad_pulldown_en,
  input logic [47:0] pad_drive_sel
);
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);
  // all pad outputs as one word, so a stray update anywhere is seen
  wire [95:0] pads = {pad_pullup_en, pad_pulldown_en, pad_drive_sel};

  property p_rd_idle; !$past(bus_rd) |-> bus_rdata == 32'h0; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  property p_hi_zero; bus_rdata[31:16] == 16'h0; endproperty
  a_hi_zero: assert property (p_hi_zero) else $error("upper read bits set");
  property p_pull_excl; (pad_pullup_en & pad_pulldown_en) == 24'h0; endproperty
  a_pull_excl: assert property (p_pull_excl) else $error("both pulls on");
  property p_fixed_drv;
    pad_drive_sel[31:16] == 16'h5555 && pad_drive_sel[41:40] == 2'h1;
  endproperty
  a_fixed_drv: assert property (p_fixed_drv) else $error("fixed drive moved");
  property p_pad_hold; !$past(bus_wr) |-> $stable(pads); endproperty
  a_pad_hold: assert property (p_pad_hold) else $error("pads moved no write");
  property p_pad_cause;
    !$stable(pads) |-> $past(bus_addr) >= 12'h220 && $past(bus_addr) <= 12'h237;
  endproperty
  a_pad_cause: assert property (p_pad_cause) else $error("pads moved bad addr");
  property p_unmapped; $past(bus_rd) && $past(bus_addr) == 12'h238 |-> bus_rdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not 0");
  property p_half_hi;
    $past(bus_rd) && $past(bus_half) && $past(bus_addr[1]) |-> bus_rdata == 32'h0;
  endproperty
  a_half_hi: assert property (p_half_hi) else $error("upper half not 0");
endmodule

bind pbc_regs pbc_regs_monitor u_mon (.sys_clk(sys_clk), .sys_rst(sys_rst),
  .bus_addr(bus_addr), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_half(bus_half),
  .bus_rdata(bus_rdata), .pad_pullup_en(pad_pullup_en),
  .pad_pulldown_en(pad_pulldown_en), .pad_drive_sel(pad_drive_sel));

// ==== pbc_regs_tb_top.sv ====
// self-checking bench for the pad buffer configuration bank
`timescale 1ns/1ps
`include "pbc_consts.vh"
module pbc_regs_tb_top;
  logic        sys_clk = 0, sys_rst = 1, bus_wr = 0, bus_rd = 0, bus_half = 0;
  logic [11:0] bus_addr = 12'h0;
  logic [31:0] bus_wdata = 32'h0;
  logic [31:0] bus_rdata;
  logic [23:0] pad_pullup_en, pad_pulldown_en;
  logic [47:0] pad_drive_sel;
  int          mismatches = 0, num_checks = 0;

  pbc_regs u_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_half(bus_half),
    .bus_rdata(bus_rdata), .pad_pullup_en(pad_pullup_en),
    .pad_pulldown_en(pad_pulldown_en), .pad_drive_sel(pad_drive_sel));

  // 25 ns period
  initial forever #12.5 sys_clk = ~sys_clk;

  task chk(input logic [47:0] seen, exp, input string nm);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // idle cycle after each strobe so no signal is set twice in one step
  task wr(input logic [11:0] a, input logic [31:0] d, input logic h);
    bus_addr <= a;
    bus_wdata <= d;
    bus_half <= h;
    bus_wr <= 1'b1;
    @(posedge sys_clk);
    bus_wr <= 1'b0;
    @(posedge sys_clk);
  endtask
  task rd(input logic [11:0] a, input logic h, input logic [31:0] e);
    bus_addr <= a;
    bus_half <= h;
    bus_rd <= 1'b1;
    @(posedge sys_clk);
    bus_rd <= 1'b0;
    #1 chk(bus_rdata, e, "rdata");
    @(posedge sys_clk);
  endtask
  task unlock;
    wr(`PBC_OFS_UNLOCK, `PBC_KEY_A, 1'b0);
    wr(`PBC_OFS_UNLOCK, `PBC_KEY_B, 1'b0);
  endtask
  task stop_test;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // tests need about 75 cycles; 800 leaves ample margin
  initial begin
    #20000;
    mismatches++;
    stop_test;
  end

  // main sequence
  initial begin
    repeat (5) @(posedge sys_clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 6; i++)
      rd(12'h220 + 12'(4 * i), 1'b0, 32'h9999);
    chk(pad_pullup_en, 24'hFFFFFF, "pullup");
    chk(pad_drive_sel, {24{2'h1}}, "drive");
    rd(12'h238, 1'b0, 32'h0);
    $display("reset test done");
    // broken key sequence leaves the bank locked
    wr(`PBC_OFS_UNLOCK, `PBC_KEY_A, 1'b0);
    wr(`PBC_OFS_UNLOCK, 32'h11, 1'b0);
    wr(`PBC_OFS_UNLOCK, `PBC_KEY_B, 1'b0);
    wr(12'h220, 32'h0, 1'b0);
    rd(12'h220, 1'b0, 32'h9999);
    chk(pad_pullup_en, 24'hFFFFFF, "pullup");
    $display("lock test done");
    // pull codes 00, 01 and 10, both drive codes, upper bits written as ones
    unlock;
    wr(12'h220, 32'hFFFF9B71, 1'b0);
    chk(pad_pullup_en[3:0], 4'hC, "pullup");
    chk(pad_pulldown_en[3:0], 4'h2, "pulldown");
    chk(pad_drive_sel[7:0], 8'h7D, "drive");
    rd(12'h220, 1'b0, 32'h9B71);
    wr(12'h220, 32'h0, 1'b0);
    rd(12'h220, 1'b0, 32'h9B71);
    $display("field test done");
    // half-word access to a port without drive control
    unlock;
    wr(12'h228, 32'h0, 1'b1);
    rd(12'h228, 1'b0, 32'h1111);
    rd(12'h228, 1'b1, 32'h1111);
    rd(12'h22A, 1'b1, 32'h0);
    chk(pad_pullup_en[11:8], 4'h0, "pullup");
    // mixed register: lowest pin has fixed drive
    unlock;
    wr(12'h234, 32'h5554, 1'b0);
    rd(12'h234, 1'b0, 32'h5555);
    chk(pad_pulldown_en[23:20], 4'hF, "pulldown");
    $display("half test done");
    // prohibited pull code, and the status word around one unlock
    unlock;
    rd(`PBC_OFS_STATUS, 1'b0, 32'h1);
    wr(12'h224, 32'hD999, 1'b0);
    chk(pad_pullup_en[7:4], 4'hF, "pullup");
    chk(pad_pulldown_en[7:4], 4'h0, "pulldown");
    rd(12'h224, 1'b0, 32'hD999);
    rd(`PBC_OFS_STATUS, 1'b0, 32'h0);
    $display("status test done");
    stop_test;
  end
endmodule

// ==== pbc_unlock.v ====
// protection unlock sequencer: two-key write sequence opens one write
`timescale 1ns/1ps
`include "pbc_consts.vh"

module pbc_unlock (
  input  wire        sys_clk,
  input  wire        sys_rst,
  input  wire        key_wr,
  input  wire [15:0] key_data,
  input  wire        cfg_wr_done,
  output reg         unlocked_r
);

  // ----------------------------------------
  // sequence states
  // ----------------------------------------
  localparam ST_LOCKED = 2'd0;
  localparam ST_KEY_A  = 2'd1;
  localparam ST_OPEN   = 2'd2;

  reg [1:0] state_r;
  reg [1:0] state_nxt;

  // next state: a wrong key always falls back to locked
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_LOCKED: begin
        if (key_wr && key_data == `PBC_KEY_A) begin
          state_nxt = ST_KEY_A;
        end
      end
      ST_KEY_A: begin
        if (key_wr) begin
          state_nxt = (key_data == `PBC_KEY_B) ? ST_OPEN : ST_LOCKED;
        end
      end
      ST_OPEN: begin
        // one config write consumes the unlock, so a stray write cannot follow
        if (cfg_wr_done || key_wr) begin
          state_nxt = ST_LOCKED;
        end
      end
      default: begin
        state_nxt = ST_LOCKED;
      end
    endcase
  end

  // state register
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_r    <= ST_LOCKED;
      unlocked_r <= 1'b0;
    end else begin
      state_r    <= state_nxt;
      unlocked_r <= (state_nxt == ST_OPEN);
    end
  end

endmodule
